// File: logic/ilc_level_ctrl.sv
// input level controller: peak measure, gain stepping, avalon registers
//
// Behaviour
// - measure decimated samples, not amplifier output
// - peak loads larger magnitude, else decays
// - normal mode gain never above ceiling; here only increases are capped
// - limiter ceiling is gain captured at enable
// - gain never below floor in any mode
// - target is fraction of full scale
// - instantaneous level over target steps gain down
// - reduction stops 1.5dB below target peak
// - 1.5dB below target steps gain up
// - decay code sets interval between increases
// - limiter mode uses shorter time tables
// - peak below target for hold before increase
// - over 87.5% ramps down at fastest rate
// - gate enable bit and threshold code
// - asserted gate freezes gain, no increase; here clip and attack still step gain down
// - gate only in enabled normal mode
// - gate compares input-referred level with threshold
// - channel enable codes off, right, left, both
// - limiter when mode bit and enabled
// - times per 0.75dB step, doubling per code
// - shared settings, disabled channel keeps gain
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ilc_level_ctrl
    import ilc_pkg::*;
#(
    parameter int TICK_CYC = ILC_TICK_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // decimator samples and boost stage
    input  wire ilc_samp_t   samp,
    input  wire logic        boost_l,
    input  wire logic        boost_r,
    // amplifier gain codes
    output ilc_gain_t        gain
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [22:0] mag_of(input logic [23:0] s);
        logic [23:0] n;
        n = -s;
        if (!s[23]) begin
            mag_of = s[22:0];
        end else if (s == 24'h800000) begin
            mag_of = 23'h7fffff;
        end else begin
            mag_of = n[22:0];
        end
    endfunction : mag_of

    // level table: index 1..15 is target -22.5..-1.5dBFS, 16 is 0dBFS, 0 is -24dBFS
    function automatic logic [15:0] lvl_of(input logic [4:0] i);
        case (i)
            5'd0:    lvl_of = 16'h1027;
            5'd1:    lvl_of = 16'h1333;
            5'd2:    lvl_of = 16'h16d1;
            5'd3:    lvl_of = 16'h1b1e;
            5'd4:    lvl_of = 16'h203a;
            5'd5:    lvl_of = 16'h264e;
            5'd6:    lvl_of = 16'h2d86;
            5'd7:    lvl_of = 16'h361b;
            5'd8:    lvl_of = 16'h404e;
            5'd9:    lvl_of = 16'h4c6d;
            5'd10:   lvl_of = 16'h5ad5;
            5'd11:   lvl_of = 16'h6bf4;
            5'd12:   lvl_of = 16'h804e;
            5'd13:   lvl_of = 16'h987d;
            5'd14:   lvl_of = 16'hb53d;
            5'd15:   lvl_of = 16'hd73c;
            default: lvl_of = 16'hffff;
        endcase
    endfunction : lvl_of

    // interval in ticks: base doubled per code, code capped
    function automatic logic [16:0] span_of(input int base, input logic [3:0] code);
        logic [3:0] c;
        c = (code > 4'(ILC_CODE_MAX)) ? 4'(ILC_CODE_MAX) : code;
        span_of = 17'(base) << c;
    endfunction : span_of

    // ************************************************************
    // avalon slave: one wait cycle per access
    // ************************************************************
    logic       ack_q;
    logic [8:0] limits_q;
    logic [7:0] level_q;
    logic [8:0] timing_q;
    logic [3:0] gate_q;
    logic [31:0] status_w;
    logic       wr_en;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_en           = avs_write & ack_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    function automatic logic [8:0] merge9(input logic [8:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        merge9 = old;
        if (be[0]) begin
            merge9[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge9[8] = wd[8];
        end
    endfunction : merge9

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            limits_q <= ILC_RST_LIMITS;
            level_q  <= ILC_RST_LEVEL;
            timing_q <= ILC_RST_TIMING;
            gate_q   <= ILC_RST_GATE;
        end else if (wr_en) begin
            case (avs_address)
                ILC_ADDR_LIMITS: limits_q <= merge9(limits_q, avs_writedata, avs_byteenable);
                ILC_ADDR_LEVEL: begin
                    if (avs_byteenable[0]) begin
                        level_q <= avs_writedata[7:0];
                    end
                end
                ILC_ADDR_TIMING: timing_q <= merge9(timing_q, avs_writedata, avs_byteenable);
                ILC_ADDR_GATE: begin
                    if (avs_byteenable[0]) begin
                        gate_q <= avs_writedata[3:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (avs_read & ~ack_q) begin
            case (avs_address)
                ILC_ADDR_LIMITS: avs_readdata <= {23'h0, limits_q};
                ILC_ADDR_LEVEL:  avs_readdata <= {24'h0, level_q};
                ILC_ADDR_TIMING: avs_readdata <= {23'h0, timing_q};
                ILC_ADDR_GATE:   avs_readdata <= {28'h0, gate_q};
                ILC_ADDR_STATUS: avs_readdata <= status_w;
                default:         avs_readdata <= '0;
            endcase
        end
    end

    // ************************************************************
    // settings
    // ************************************************************
    logic [2:0] floor_code;
    logic [2:0] ceil_code;
    logic [1:0] chen;
    logic [3:0] tgt_code;
    logic [3:0] hold_code;
    logic [3:0] atk_code;
    logic [3:0] dcy_code;
    logic       lim_sel;
    logic [2:0] gth_code;
    logic       gate_en;
    logic       ctl_en;
    logic       lim_act;

    assign floor_code = limits_q[ILC_FLOOR_LSB +: 3];
    assign ceil_code  = limits_q[ILC_CEIL_LSB +: 3];
    assign chen       = limits_q[ILC_CHEN_LSB +: 2];
    assign tgt_code   = level_q[ILC_TGT_LSB +: 4];
    assign hold_code  = level_q[ILC_HOLD_LSB +: 4];
    assign atk_code   = timing_q[ILC_ATK_LSB +: 4];
    assign dcy_code   = timing_q[ILC_DCY_LSB +: 4];
    assign lim_sel    = timing_q[ILC_LIM_BIT];
    assign gth_code   = gate_q[ILC_GTH_LSB +: 3];
    assign gate_en    = gate_q[ILC_GEN_BIT];
    assign ctl_en     = chen != 2'b00;
    assign lim_act    = lim_sel & ctl_en;

    // ************************************************************
    // measurement
    // ************************************************************
    logic [22:0] mag_l;
    logic [22:0] mag_r;
    logic [22:0] mag_sel;
    logic [22:0] peak;
    logic [15:0] inst_q;
    logic [15:0] peak16;
    logic [15:0] tgt_lvl;
    logic [15:0] low_lvl;

    assign mag_l = mag_of(samp.left);
    assign mag_r = mag_of(samp.right);
    // both channels share one loop, so watch the louder enabled one
    always_comb begin
        mag_sel = '0;
        if (chen[1] && mag_l > mag_sel) begin
            mag_sel = mag_l;
        end
        if (chen[0] && mag_r > mag_sel) begin
            mag_sel = mag_r;
        end
    end

    ilc_peak_det u_peak (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .mag_valid (samp.valid),
        .mag       (mag_sel),
        .peak_q    (peak)
    );

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            inst_q <= '0;
        end else if (samp.valid) begin
            inst_q <= mag_sel[22:7];
        end
    end

    assign peak16  = peak[22:7];
    assign tgt_lvl = lvl_of(5'(tgt_code) + 5'd1);
    assign low_lvl = lvl_of(5'(tgt_code));

    // ************************************************************
    // timebase
    // ************************************************************
    logic [15:0] pre_q;
    logic        tick;

    assign tick = pre_q == 16'(TICK_CYC - 1);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q <= '0;
        end else begin
            pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
        end
    end

    // ************************************************************
    // conditions
    // ************************************************************
    logic        clip;
    logic        attack_q;
    logic [16:0] hold_q;
    logic [16:0] hold_need;
    logic        hold_done;
    logic        gate_on;
    logic [5:0]  gain_q;

    assign clip = ctl_en && inst_q > ILC_CLIP_LVL;

    // set wins over the low-peak clear; the disable clear wins over both
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            attack_q <= 1'b0;
        end else if (!ctl_en) begin
            attack_q <= 1'b0;
        end else if (inst_q > tgt_lvl) begin
            attack_q <= 1'b1;
        end else if (peak16 < low_lvl) begin
            attack_q <= 1'b0;
        end
    end

    assign hold_need = (hold_code == 4'h0) ? 17'h0 : span_of(ILC_HOLD_U, hold_code);
    assign hold_done = hold_q >= hold_need;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= '0;
        end else if (peak16 >= tgt_lvl || !ctl_en) begin
            hold_q <= '0;
        end else if (tick && !hold_done) begin
            hold_q <= hold_q + 17'h1;
        end
    end

    // gate in 0.75dB units: level from peak msb, minus gain and boost
    always_comb begin
        logic signed [11:0] lvl_u;
        logic signed [11:0] ref_u;
        logic signed [11:0] thr_u;
        lvl_u = -12'sd184;
        for (int i = 0; i < 23; i++) begin
            if (peak[i]) begin
                lvl_u = 12'(8 * (i - 22));
            end
        end
        ref_u = lvl_u - 12'(int'(gain_q) - int'(ILC_GAIN_0DB));
        if ((chen[1] && boost_l) || (chen[0] && boost_r)) begin
            ref_u = ref_u - 12'(ILC_BOOST_U);
        end
        thr_u = 12'(ILC_GATE_TOP_U - ILC_GATE_STEP * int'(gth_code));
        gate_on = gate_en && ctl_en && !lim_act && (ref_u < thr_u);
    end

    // ************************************************************
    // decision and gain stepping
    // ************************************************************
    ilc_act_t    act;
    ilc_act_t    act_q;
    logic [16:0] span;
    logic [16:0] step_q;
    logic [5:0]  ceil_g;
    logic [5:0]  floor_g;
    logic [5:0]  lim_ceil_q;
    logic        lim_act_q;
    logic [5:0]  next_g;

    always_comb begin
        act = ILC_ACT_IDLE;
        if (!ctl_en) begin
            act = ILC_ACT_IDLE;
        end else if (clip || attack_q) begin
            act = ILC_ACT_DOWN;
        end else if (gate_on) begin
            act = ILC_ACT_HOLD;
        end else if (peak16 < low_lvl && hold_done) begin
            act = ILC_ACT_UP;
        end
    end

    always_comb begin
        case (act)
            ILC_ACT_DOWN: begin
                if (clip) begin
                    span = 17'(ILC_ATK_LIM_U);
                end else begin
                    span = span_of(lim_act ? ILC_ATK_LIM_U : ILC_ATK_NORM_U, atk_code);
                end
            end
            ILC_ACT_UP: span = span_of(lim_act ? ILC_DCY_LIM_U : ILC_DCY_NORM_U, dcy_code);
            default:    span = 17'h1ffff;
        endcase
    end

    assign ceil_g  = lim_act ? lim_ceil_q : {ceil_code, 3'b111};
    assign floor_g = {floor_code, 3'b000};

    always_comb begin
        next_g = gain_q;
        if (act == ILC_ACT_DOWN && gain_q != 6'h00) begin
            next_g = gain_q - 6'h01;
        end else if (act == ILC_ACT_UP && gain_q != 6'h3f) begin
            next_g = gain_q + 6'h01;
        end
        if (act == ILC_ACT_UP && next_g > ceil_g) begin
            next_g = (gain_q > ceil_g) ? gain_q : ceil_g;
        end
        if (next_g < floor_g) begin
            next_g = floor_g;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lim_act_q  <= 1'b0;
            lim_ceil_q <= ILC_RST_GAIN;
        end else begin
            lim_act_q <= lim_act;
            if (lim_act && !lim_act_q) begin
                lim_ceil_q <= gain_q;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            act_q  <= ILC_ACT_IDLE;
            step_q <= '0;
            gain_q <= ILC_RST_GAIN;
        end else begin
            act_q <= act;
            if (act != act_q) begin
                step_q <= '0;
            end else if (tick && (act == ILC_ACT_DOWN || act == ILC_ACT_UP)) begin
                if (step_q + 17'h1 >= span) begin
                    step_q <= '0;
                    gain_q <= next_g;
                end else begin
                    step_q <= step_q + 17'h1;
                end
            end
        end
    end

    // disabled channel keeps its last gain
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            gain <= '{gain_l: ILC_RST_GAIN, gain_r: ILC_RST_GAIN};
        end else begin
            if (chen[1]) begin
                gain.gain_l <= gain_q;
            end
            if (chen[0]) begin
                gain.gain_r <= gain_q;
            end
        end
    end

    assign status_w = {peak16, 4'h0, clip, gate_on, attack_q, lim_act, 2'b00, gain_q};

endmodule : ilc_level_ctrl
`default_nettype wire

// File: logic/ilc_pkg.sv
// shared constants and types of the input level controller
package ilc_pkg;

    // ************************************************************
    // register map (index x4 = byte address)
    // ************************************************************
    localparam int ILC_IDX_LIMITS = 32;
    localparam int ILC_IDX_LEVEL  = 33;
    localparam int ILC_IDX_TIMING = 34;
    localparam int ILC_IDX_GATE   = 35;
    localparam int ILC_IDX_STATUS = 36;
    localparam logic [7:0] ILC_ADDR_LIMITS = 8'(ILC_IDX_LIMITS * 4);
    localparam logic [7:0] ILC_ADDR_LEVEL  = 8'(ILC_IDX_LEVEL * 4);
    localparam logic [7:0] ILC_ADDR_TIMING = 8'(ILC_IDX_TIMING * 4);
    localparam logic [7:0] ILC_ADDR_GATE   = 8'(ILC_IDX_GATE * 4);
    localparam logic [7:0] ILC_ADDR_STATUS = 8'(ILC_IDX_STATUS * 4);

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ILC_FLOOR_LSB = 0;
    localparam int ILC_CEIL_LSB  = 3;
    localparam int ILC_CHEN_LSB  = 7;
    localparam int ILC_TGT_LSB   = 0;
    localparam int ILC_HOLD_LSB  = 4;
    localparam int ILC_ATK_LSB   = 0;
    localparam int ILC_DCY_LSB   = 4;
    localparam int ILC_LIM_BIT   = 8;
    localparam int ILC_GTH_LSB   = 0;
    localparam int ILC_GEN_BIT   = 3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [8:0] ILC_RST_LIMITS = 9'h038;
    localparam logic [7:0] ILC_RST_LEVEL  = 8'h0b;
    localparam logic [8:0] ILC_RST_TIMING = 9'h032;
    localparam logic [3:0] ILC_RST_GATE   = 4'h0;
    localparam logic [5:0] ILC_RST_GAIN   = 6'h10;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int ILC_CLK_NS      = 25;
    localparam int ILC_TICK_NS     = 31250;
    localparam int ILC_TICK_CYC    = (ILC_TICK_NS + ILC_CLK_NS - 1) / ILC_CLK_NS;
    localparam int ILC_ATK_NORM_NS = 125000;
    localparam int ILC_ATK_LIM_NS  = 31000;
    localparam int ILC_DCY_NORM_NS = 500000;
    localparam int ILC_DCY_LIM_NS  = 125000;
    localparam int ILC_HOLD_NS     = 1000000;
    localparam int ILC_ATK_NORM_U  = (ILC_ATK_NORM_NS + ILC_TICK_NS - 1) / ILC_TICK_NS;
    localparam int ILC_ATK_LIM_U   = (ILC_ATK_LIM_NS + ILC_TICK_NS - 1) / ILC_TICK_NS;
    localparam int ILC_DCY_NORM_U  = (ILC_DCY_NORM_NS + ILC_TICK_NS - 1) / ILC_TICK_NS;
    localparam int ILC_DCY_LIM_U   = (ILC_DCY_LIM_NS + ILC_TICK_NS - 1) / ILC_TICK_NS;
    localparam int ILC_HOLD_U      = (ILC_HOLD_NS + ILC_TICK_NS - 1) / ILC_TICK_NS;
    localparam int ILC_CODE_MAX    = 10;

    // ************************************************************
    // levels (fraction of full scale x 65536), gain units 0.75dB
    // ************************************************************
    localparam logic [15:0] ILC_CLIP_LVL = 16'he000;
    localparam logic [5:0]  ILC_GAIN_0DB = 6'h10;
    localparam int ILC_BOOST_U    = 27;
    localparam int ILC_GATE_TOP_U = -52;
    localparam int ILC_GATE_STEP  = 8;
    localparam int ILC_PEAK_SHIFT = 12;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
        logic        valid;
    } ilc_samp_t;

    typedef struct packed {
        logic [5:0] gain_l;
        logic [5:0] gain_r;
    } ilc_gain_t;

    typedef enum logic [1:0] {
        ILC_ACT_IDLE = 2'b00,
        ILC_ACT_UP   = 2'b01,
        ILC_ACT_HOLD = 2'b11,
        ILC_ACT_DOWN = 2'b10
    } ilc_act_t;

endpackage : ilc_pkg

// File: logic/ilc_peak_det.sv
// decaying peak detector on sample magnitudes
`timescale 1ns/1ps
`default_nettype none
module ilc_peak_det
    import ilc_pkg::*;
#(
    parameter int MAG_W = 23,
    parameter int SHIFT = ILC_PEAK_SHIFT
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // magnitude stream
    input  wire logic             mag_valid,
    input  wire logic [MAG_W-1:0] mag,
    // held peak
    output logic      [MAG_W-1:0] peak_q
);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            peak_q <= '0;
        end else if (mag_valid) begin
            if (mag > peak_q) begin
                peak_q <= mag;
            end else if (peak_q != '0) begin
                // at least one lsb so the peak reaches zero
                peak_q <= peak_q - ((peak_q >> SHIFT) | MAG_W'(1));
            end
        end
    end

endmodule : ilc_peak_det
`default_nettype wire

// File: tb/ilc_adc_model.sv
// decimator model: alternating-sign samples at a bench-set level
`timescale 1ns/1ps
`default_nettype none
module ilc_adc_model
    import ilc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // level asked for
    input  wire logic [23:0] level,
    // decimated samples
    output var  ilc_samp_t   samp
);
    // ************************************************************
    // sample stream, one every four cycles
    // ************************************************************
    logic [1:0] cnt_q;
    logic       neg_q;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 2'h0;
            neg_q <= 1'b0;
            samp  <= '0;
        end else begin
            cnt_q      <= cnt_q + 2'h1;
            samp.valid <= (cnt_q == 2'h3);
            if (cnt_q == 2'h3) begin
                neg_q      <= ~neg_q;
                samp.left  <= neg_q ? -level : level;
                samp.right <= neg_q ? -level : level;
            end else begin
                // lines are inverted every cycle between samples
                samp.left  <= ~samp.left;
                samp.right <= ~samp.right;
            end
        end
    end
endmodule : ilc_adc_model
`default_nettype wire

// File: tb/ilc_level_ctrl_props.sv
// checker for the level controller ports
`timescale 1ns/1ps
`default_nettype none
module ilc_level_ctrl_props
    import ilc_pkg::*;
#(
    parameter int TICK_CYC = ILC_TICK_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // avalon-mm
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // gain
    input  wire ilc_gain_t   gain
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ************************************************************
    // shadow of settings and capture
    // ************************************************************
    logic [8:0] lim_q;
    logic       sel_q;
    logic       act_q;
    logic [5:0] cap_q;
    int         gap_q;
    wire        wok = avs_write && !avs_waitrequest;
    wire        act = sel_q && (lim_q[8:7] != 2'h0);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lim_q <= ILC_RST_LIMITS;
            sel_q <= ILC_RST_TIMING[8];
        end else begin
            if (wok && avs_address == ILC_ADDR_LIMITS) lim_q <= avs_writedata[8:0];
            if (wok && avs_address == ILC_ADDR_TIMING) sel_q <= avs_writedata[8];
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            act_q <= 1'b0;
            cap_q <= ILC_RST_GAIN;
        end else begin
            act_q <= act;
            if (act && !act_q) cap_q <= gain.gain_l;
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) gap_q <= TICK_CYC;
        else if ($changed(gain) && $past(lim_q, 2) == lim_q) gap_q <= 0;
        else if (gap_q < TICK_CYC) gap_q <= gap_q + 1;
    end
    // ************************************************************
    // properties
    // ************************************************************
    property p_wait;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait cycle wrong");
    property p_unmap;
        avs_read && !avs_waitrequest && avs_address == 8'h00 |-> avs_readdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_gap;
        $changed(gain) && $past(lim_q, 2) == lim_q |-> gap_q >= TICK_CYC - 1;
    endproperty
    a_gap: assert property (p_gap) else $error("gain step off tick");
    property p_step;
        $past(lim_q[8], 2) && $changed(gain.gain_l)
            |-> (gain.gain_l == $past(gain.gain_l) + 6'h01)
            || (gain.gain_l == $past(gain.gain_l) - 6'h01);
    endproperty
    a_step: assert property (p_step) else $error("gain moved by more than one");
    property p_floor;
        $changed(gain.gain_l) |-> gain.gain_l >= {lim_q[2:0], 3'h0};
    endproperty
    a_floor: assert property (p_floor) else $error("gain below floor");
    property p_ceil;
        !act && gain.gain_l > $past(gain.gain_l) |-> gain.gain_l <= {lim_q[5:3], 3'h7};
    endproperty
    a_ceil: assert property (p_ceil) else $error("gain raised above ceiling");
    property p_lim;
        act_q && gain.gain_l > $past(gain.gain_l) |-> gain.gain_l <= cap_q;
    endproperty
    a_lim: assert property (p_lim) else $error("limiter ceiling passed");
    property p_keep;
        !lim_q[8] |=> $stable(gain.gain_l);
    endproperty
    a_keep: assert property (p_keep) else $error("disabled left gain moved");
endmodule : ilc_level_ctrl_props
bind ilc_level_ctrl ilc_level_ctrl_props #(.TICK_CYC(TICK_CYC)) u_props (.clk_sys, .sys_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .gain);
`default_nettype wire

// File: tb/ilc_level_ctrl_tb.sv
// testbench of the level controller
`timescale 1ns/1ps
`default_nettype none
module ilc_level_ctrl_tb
    import ilc_pkg::*;
;
    // ************************************************************
    // signals, design and model
    // ************************************************************
    logic        clk_sys, sys_rst, rd, wr, wait_req;
    logic [7:0]  addr;
    logic [31:0] wd, rdata, rdv;
    logic [23:0] lvl;
    ilc_samp_t   samp;
    ilc_gain_t   gain;
    int          num_errors, n_checks;
    ilc_adc_model i_src (.clk_sys, .sys_rst, .level(lvl), .samp);
    ilc_level_ctrl #(.TICK_CYC(10)) i_dut (.clk_sys, .sys_rst, .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .samp, .boost_l(1'b0),
        .boost_r(1'b0), .gain);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        addr <= a;
        wd   <= d;
        rd   <= !w;
        wr   <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (wait_req === 1'b0) break;
        end
        if (i == 20) begin
            chk("bus answer", 32'h1, 32'h0);
            summarize();
        end
        rdv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readback", e, rdv);
    endtask : rdchk
    task automatic wt(input logic r, input logic [5:0] v, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if ((r ? gain.gain_r : gain.gain_l) === v) break;
        end
        chk("gain reached", 32'(v), 32'(r ? gain.gain_r : gain.gain_l));
        if (i == n) summarize();
    endtask : wt
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        sys_rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 8'h00; wd = 32'h0; lvl = 24'h000100;
        num_errors = 0; n_checks = 0;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk("reset gain", 32'(ILC_RST_GAIN), 32'(gain.gain_r));
        rdchk(ILC_ADDR_LIMITS, 32'(ILC_RST_LIMITS));
        rdchk(ILC_ADDR_LEVEL, 32'(ILC_RST_LEVEL));
        rdchk(ILC_ADDR_TIMING, 32'(ILC_RST_TIMING));
        rdchk(ILC_ADDR_GATE, 32'(ILC_RST_GATE));
        rdchk(8'h00, 32'h0);
        bus(1'b1, ILC_ADDR_GATE, 32'h8);
        bus(1'b1, ILC_ADDR_TIMING, 32'h000);
        bus(1'b1, ILC_ADDR_LIMITS, 32'h199);
        repeat (1000) @(posedge clk_sys);
        chk("gate hold", 32'h10, 32'(gain.gain_l));
        bus(1'b1, ILC_ADDR_GATE, 32'h0);
        wt(1'b0, 6'h1f, 6000);
        repeat (400) @(posedge clk_sys);
        chk("at ceiling", 32'h1f, 32'(gain.gain_l));
        lvl <= 24'h600000;
        wt(1'b0, 6'h08, 3000);
        repeat (300) @(posedge clk_sys);
        chk("at floor", 32'h08, 32'(gain.gain_l));
        bus(1'b1, ILC_ADDR_TIMING, 32'h100);
        lvl <= 24'h010000;
        repeat (12000) @(posedge clk_sys);
        chk("limiter cap", 32'h08, 32'(gain.gain_l));
        bus(1'b1, ILC_ADDR_TIMING, 32'h000);
        bus(1'b1, ILC_ADDR_LIMITS, 32'h099);
        wt(1'b1, 6'h1f, 6000);
        chk("left kept", 32'h08, 32'(gain.gain_l));
        bus(1'b1, ILC_ADDR_LIMITS, 32'h198);
        bus(1'b1, ILC_ADDR_TIMING, 32'h00a);
        lvl <= 24'h7f0000;
        repeat (250) @(posedge clk_sys);
        chk("clip ramp", 32'h1, 32'(gain.gain_r < 6'h10));
        summarize();
    end
endmodule : ilc_level_ctrl_tb
`default_nettype wire
